// ===== verif/tb.sv
// self-checking bench for the eeprom program/erase controller
`timescale 1ns/1ps
`include "epc_params.svh"
module tb;
  import epc_pkg::*;
  logic     clk_i = 1'b0;
  logic     sys_rst_i = 1'b1;
  logic     prot = 1'b1;
  logic     secure = 1'b0;
  logic     sc_o;
  epc_bus_t bus_i = '0;
  logic [7:0] rdata_o;
  logic [7:0] config_o;
  logic     hv_on_o;
  int       err_total = 0;
  int       n_compared = 0;
  // clock far above 1 MHz, pump stays on bus clock
  always #2 clk_i = ~clk_i;
  epc_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .config_protect_bit_i(prot), .array_protect_i(1'b0), .security_i(secure),
    .single_chip_req_i(1'b0), .hv_on_o(hv_on_o), .single_chip_o(sc_o), .config_o(config_o));
  // ****************
  // bus tasks
  // ****************
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{1'b0, 1'b1, a, d};
    @(posedge clk_i);
    bus_i <= '0;
  endtask
  task automatic chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    bus_i <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk_i);
    bus_i <= '0;
    #1 cmp(rdata_o, e);
  endtask
  // latch, store, voltage on, hold, clear; hold is short since software times it
  task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    wr(`EPC_CTRL_ADDR, c);
    wr(a, d);
    wr(`EPC_CTRL_ADDR, c | 8'h01);
    repeat (3) @(posedge clk_i);
    #1 cmp({7'h00, hv_on_o}, 8'h01);
    wr(`EPC_CTRL_ADDR, 8'h00);
    @(posedge clk_i);
    #1 cmp({7'h00, hv_on_o}, 8'h00);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_prog();
    chk(`EPC_CTRL_ADDR, 8'h00);
    chk(16'hb600, 8'hff);
    cmp(config_o, 8'hff);
    op(8'h02, 16'hb610, 8'h5a);
    chk(16'hb610, 8'h5a);
    op(8'h02, 16'hb610, 8'hff);
    chk(16'hb610, 8'h5a);
    op(8'h1a, 16'hb611, 8'h0f);
    chk(16'hb611, 8'h0f);
    chk(16'hb610, 8'h5a);
    $display("program test done");
  endtask
  task automatic t_refuse();
    wr(`EPC_CTRL_ADDR, 8'h03);
    chk(`EPC_CTRL_ADDR, 8'h00);
    wr(`EPC_CTRL_ADDR, 8'h01);
    chk(`EPC_CTRL_ADDR, 8'h00);
    wr(16'hb630, 8'h00);
    chk(16'hb630, 8'hff);
    chk(16'hb610, 8'h5a);
    wr(`EPC_CTRL_ADDR, 8'h20);
    chk(`EPC_CTRL_ADDR, 8'h20);
    wr(`EPC_CTRL_ADDR, 8'h02);
    chk(`EPC_CTRL_ADDR, 8'h02);
    chk(16'hb610, 8'hff);
    wr(`EPC_CTRL_ADDR, 8'h00);
    chk(16'hb610, 8'h5a);
    $display("refusal test done");
  endtask
  task automatic t_erase();
    op(8'h02, 16'hb620, 8'h00);
    op(8'h02, 16'hb621, 8'h00);
    op(8'h02, 16'hb622, 8'h00);
    op(8'h16, 16'hb620, 8'h00);
    chk(16'hb620, 8'hff);
    chk(16'hb621, 8'h00);
    op(8'h1e, 16'hb622, 8'h00);
    chk(16'hb622, 8'hff);
    chk(16'hb621, 8'h00);
    op(8'h0e, 16'hb62f, 8'h00);
    chk(16'hb621, 8'hff);
    chk(16'hb610, 8'h5a);
    chk(16'hb611, 8'h0f);
    op(8'h06, 16'hb7ff, 8'h00);
    chk(16'hb610, 8'hff);
    chk(16'hb611, 8'hff);
    op(8'h02, 16'hb610, 8'ha5);
    chk(16'hb610, 8'ha5);
    $display("erase test done");
  endtask
  task automatic t_cfg();
    op(8'h02, `EPC_CFG_ADDR, 8'h3c);
    cmp(config_o, 8'hff);
    @(posedge clk_i);
    prot <= 1'b0;
    op(8'h02, `EPC_CFG_ADDR, 8'h3c);
    cmp(config_o, 8'h3c);
    op(8'h06, 16'hb600, 8'h00);
    cmp(config_o, 8'h3c);
    op(8'h16, `EPC_CFG_ADDR, 8'h00);
    cmp(config_o, 8'hff);
    op(8'h02, `EPC_CFG_ADDR, 8'h96);
    cmp(config_o, 8'h96);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk(`EPC_CTRL_ADDR, 8'h00);
    $display("config test done");
  endtask
  task automatic t_mode();
    cmp({7'h00, sc_o}, 8'h00);
    @(posedge clk_i);
    secure <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 cmp({7'h00, sc_o}, 8'h01);
    @(posedge clk_i);
    secure <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 cmp({7'h00, sc_o}, 8'h00);
    $display("mode test done");
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_prog();
    t_refuse();
    t_erase();
    t_cfg();
    t_mode();
    test_done();
  end
endmodule

// ===== verilog/epc_array.sv
// eeprom cell array with program and erase pulses
`timescale 1ns/1ps
`include "epc_params.svh"
module epc_array
  import epc_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // high voltage operation
  input  wire logic                    hv_i,
  input  wire epc_op_t                 op_i,
  input  wire logic [`EPC_IDX_W-1:0]   idx_i,
  input  wire logic [7:0]              data_i,
  // read
  input  wire logic [`EPC_IDX_W-1:0]   ridx_i,
  output logic      [7:0]              rdata_o
);
  localparam int N = 1 << `EPC_IDX_W;
  // each cell owns its flop so no element has two driving processes
  logic [7:0] mem_w [N];
  assign rdata_o = mem_w[ridx_i];

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cell
      wire same_row = (g >> `EPC_ROW_SHIFT) == (idx_i >> `EPC_ROW_SHIFT);
      wire hit      = g == idx_i;
      logic [7:0] cell_q;
      assign mem_w[g] = cell_q;
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          cell_q <= `EPC_ERASED;
        end else if (hv_i) begin
          if (op_i == EPC_OP_PROG && hit) begin
            cell_q <= cell_q & data_i;
          end else if (op_i == EPC_OP_BYTE && hit) begin
            cell_q <= `EPC_ERASED;
          end else if (op_i == EPC_OP_ROW && same_row) begin
            cell_q <= `EPC_ERASED;
          end else if (op_i == EPC_OP_BULK) begin
            cell_q <= `EPC_ERASED;
          end
        end
      end
    end
  endgenerate
endmodule

// ===== verilog/epc_ctrl.sv
`timescale 1ns/1ps
`include "epc_params.svh"
module epc_ctrl (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  // cpu bus
  input  epc_pkg::epc_bus_t bus_i,
  output logic [7:0]        rdata_o,
  // protection and mode
  input  wire logic         config_protect_bit_i,
  input  wire logic         array_protect_i,
  input  wire logic         security_i,
  input  wire logic         single_chip_req_i,
  // status
  output logic              hv_on_o,
  output logic              single_chip_o,
  output logic [7:0]        config_o
);
  import epc_pkg::*;

  // ****************
  // control register
  // ****************
  logic [7:0]             ctrl_q, ctrl_d;
  logic [`EPC_IDX_W-1:0]  idx_q;
  logic [7:0]             data_q;
  logic                   cfg_sel_q;
  logic                   pend_q;
  logic [7:0]             cfg_q;
  logic [7:0]             rdata_q;
  logic                   sc_q;

  // address decode shared by the write strobe and the read mux
  function automatic logic is_ctrl(input logic [15:0] a);
    return a == `EPC_CTRL_ADDR;
  endfunction

  wire ctrl_wr = bus_i.wr && is_ctrl(bus_i.addr);
  wire arr_hit = bus_i.addr >= `EPC_ARR_BASE && bus_i.addr <= `EPC_ARR_LAST;
  wire cfg_hit = bus_i.addr == `EPC_CFG_ADDR;
  wire eeprom_latch_bit   = ctrl_q[`EPC_BIT_EEPROM_LATCH_BIT];
  wire rlat    = ctrl_q[`EPC_BIT_RLAT];
  wire pgm     = ctrl_q[`EPC_BIT_PGM];
  wire [7:0] w = bus_i.wdata & `EPC_CTRL_MASK;
  wire any_lat = eeprom_latch_bit | rlat;

  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = w;
      // voltage bit needs a latch already set
      if (!any_lat) ctrl_d[`EPC_BIT_PGM] = 1'b0;
      // latch and voltage together while latch clear sets neither
      if (!eeprom_latch_bit && w[`EPC_BIT_EEPROM_LATCH_BIT] && w[`EPC_BIT_PGM]) begin
        ctrl_d[`EPC_BIT_EEPROM_LATCH_BIT] = 1'b0;
        ctrl_d[`EPC_BIT_PGM]   = 1'b0;
      end
      // rom latch frozen while voltage on
      if (pgm) ctrl_d[`EPC_BIT_RLAT] = rlat;
      if (ctrl_d[`EPC_BIT_EEPROM_LATCH_BIT]) ctrl_d[`EPC_BIT_RLAT] = 1'b0;
    end
  end

  // latch address and data on array or config write
  wire lat_wr = bus_i.wr && eeprom_latch_bit && !pgm && (arr_hit || cfg_hit);
  // config writable only while its protect bit is clear
  wire lat_ok = cfg_hit ? !config_protect_bit_i : !array_protect_i;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q    <= `EPC_CTRL_RST;
      idx_q     <= '0;
      data_q    <= `EPC_CTRL_RST;
      cfg_sel_q <= 1'b0;
      pend_q    <= 1'b0;
    end else begin
      // zero write clears voltage and latch
      ctrl_q <= ctrl_d;
      if (lat_wr && lat_ok) begin
        idx_q     <= bus_i.addr[`EPC_IDX_W-1:0];
        data_q    <= bus_i.wdata;
        cfg_sel_q <= cfg_hit;
        pend_q    <= 1'b1;
      end else if (!ctrl_d[`EPC_BIT_EEPROM_LATCH_BIT]) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ****************
  // operation select
  // ****************
  // erase bit picks erase; program ignores row/byte
  wire epc_op_t op = !ctrl_q[`EPC_BIT_ERASE] ? EPC_OP_PROG :
                     ctrl_q[`EPC_BIT_BYTE]   ? EPC_OP_BYTE :
                     ctrl_q[`EPC_BIT_ROW]    ? EPC_OP_ROW  : EPC_OP_BULK;
  // voltage applied while bit set; no hardware timer
  wire hv = pgm && eeprom_latch_bit && pend_q;
  wire hv_arr = hv && !cfg_sel_q;
  wire [7:0] arr_rd;

  epc_array u_array (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .hv_i      (hv_arr),
    .op_i      (op),
    .idx_i     (idx_q),
    .data_i    (data_q),
    .ridx_i    (bus_i.addr[`EPC_IDX_W-1:0]),
    .rdata_o   (arr_rd)
  );

  // ****************
  // config cell and read path
  // ****************
  // bulk erase with an array address latched leaves config alone since it is its own cell
  wire cfg_prog  = hv && cfg_sel_q && op == EPC_OP_PROG;
  wire cfg_erase = hv && cfg_sel_q && op != EPC_OP_PROG;
  // array and config reads valid only while latch clear; control register reads always pass
  wire [7:0] rd_mux = ctrl_wr || is_ctrl(bus_i.addr) ? ctrl_q :
                      eeprom_latch_bit ? `EPC_ERASED :
                      arr_hit ? arr_rd :
                      cfg_hit ? cfg_q : `EPC_CTRL_RST;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q   <= `EPC_ERASED;
      rdata_q <= `EPC_CTRL_RST;
      sc_q    <= 1'b0;
    end else begin
      // program ands bits, erase sets ones
      if (cfg_prog) cfg_q <= cfg_q & data_q;
      else if (cfg_erase) cfg_q <= `EPC_ERASED;
      rdata_q <= bus_i.rd ? rd_mux : `EPC_CTRL_RST;
      sc_q    <= security_i | single_chip_req_i;
    end
  end

  assign rdata_o       = rdata_q;
  assign config_o      = cfg_q;
  assign single_chip_o = sc_q;
  assign hv_on_o       = ctrl_q[`EPC_BIT_PGM];

  // ****************
  // checks
  // ****************
  chk_latch_excl: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(ctrl_q[`EPC_BIT_EEPROM_LATCH_BIT] && ctrl_q[`EPC_BIT_RLAT])) else $error("both latches set");
  chk_both_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_wr && !eeprom_latch_bit && w[`EPC_BIT_EEPROM_LATCH_BIT] && w[`EPC_BIT_PGM] |=> !ctrl_q[`EPC_BIT_PGM]
    && !ctrl_q[`EPC_BIT_EEPROM_LATCH_BIT]) else $error("latch and voltage set together");
  chk_pgm_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_wr && !any_lat |=> !ctrl_q[`EPC_BIT_PGM]) else $error("voltage without latch");
  chk_zero_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_wr && bus_i.wdata == `EPC_CTRL_RST |=> ctrl_q == `EPC_CTRL_RST ##1 !hv_on_o)
    else $error("zero write did not clear");
  chk_latch_ignore: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bus_i.wr && !eeprom_latch_bit && !pend_q |=> !pend_q) else $error("write latched without latch bit");
  chk_cfg_prot: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cfg_hit && config_protect_bit_i && !cfg_sel_q |=> !cfg_sel_q)
    else $error("protected config latched");
  chk_secure: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    security_i |=> single_chip_o) else $error("security not single-chip");
  chk_prog_and: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cfg_prog |=> cfg_q == ($past(cfg_q) & $past(data_q))) else $error("config program wrong");

  chk_byte_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_q[`EPC_BIT_ERASE] && ctrl_q[`EPC_BIT_BYTE]
    |-> op == EPC_OP_BYTE)
    else $error("byte select not honoured");

  chk_row_pick: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_q[`EPC_BIT_ERASE] && !ctrl_q[`EPC_BIT_BYTE] && ctrl_q[`EPC_BIT_ROW]
    |-> op == EPC_OP_ROW)
    else $error("row erase not selected");

  chk_bulk_pick: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_q[`EPC_BIT_ERASE] && !ctrl_q[`EPC_BIT_BYTE] && !ctrl_q[`EPC_BIT_ROW]
    |-> op == EPC_OP_BULK)
    else $error("bulk erase not selected");

  chk_erase_sel: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_q[`EPC_BIT_ERASE]
    |-> op != EPC_OP_PROG)
    else $error("erase bit gave program");

  chk_prog_pick: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ctrl_q[`EPC_BIT_ERASE]
    |-> op == EPC_OP_PROG)
    else $error("program used row or byte");

  chk_read_array: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bus_i.rd && !eeprom_latch_bit && arr_hit && !is_ctrl(bus_i.addr)
    |=> rdata_o == $past(arr_rd))
    else $error("array read wrong");

  chk_pend_drop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !eeprom_latch_bit
    |-> !pend_q)
    else $error("pending op without latch");

  chk_latch_take: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lat_wr && lat_ok
    |=> pend_q && idx_q == $past(bus_i.addr[`EPC_IDX_W-1:0]))
    else $error("address not latched");

  chk_read_blank: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bus_i.rd && eeprom_latch_bit && !is_ctrl(bus_i.addr)
    |=> rdata_o == `EPC_ERASED)
    else $error("read passed while latched");

  chk_hv_apply: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_wr && any_lat && w[`EPC_BIT_PGM] && !(!eeprom_latch_bit && w[`EPC_BIT_EEPROM_LATCH_BIT])
    |=> hv_on_o)
    else $error("voltage not applied");

  chk_hv_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hv_on_o && !ctrl_wr
    |=> hv_on_o)
    else $error("voltage dropped without write");

  chk_zero_hv: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_wr && w == `EPC_CTRL_RST
    |=> !hv && !eeprom_latch_bit)
    else $error("zero write left operation on");

  chk_cfg_take: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lat_wr && cfg_hit && !config_protect_bit_i
    |=> cfg_sel_q && pend_q)
    else $error("config write not latched");

  // unimplemented bits read zero
  chk_ctrl_mask: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_wr
    |=> (ctrl_q & ~`EPC_CTRL_MASK) == `EPC_CTRL_RST)
    else $error("unused control bits set");

  chk_sc_plain: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !security_i && !single_chip_req_i
    |=> !single_chip_o)
    else $error("single-chip without cause");

  chk_cfg_erase: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cfg_erase
    |=> config_o == `EPC_ERASED)
    else $error("config erase wrong");

  // protected array ignores writes
  chk_arr_prot: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lat_wr && arr_hit && array_protect_i && !pend_q
    |=> !pend_q)
    else $error("protected array latched");

  // ****************
  // cover
  // ****************
  cov_prog: cover property (@(posedge clk_i) hv && op == EPC_OP_PROG);
  cov_row:  cover property (@(posedge clk_i) hv && op == EPC_OP_ROW);
  cov_bulk: cover property (@(posedge clk_i) hv && op == EPC_OP_BULK);
  cov_byte: cover property (@(posedge clk_i) hv && op == EPC_OP_BYTE);
  cov_cfg:  cover property (@(posedge clk_i) cfg_prog);
endmodule

// ===== verilog/epc_params.svh
// constants for the eeprom program/erase controller
`ifndef EPC_PARAMS_SVH
`define EPC_PARAMS_SVH
`define EPC_CTRL_ADDR     16'h103b
`define EPC_ARR_BASE      16'hb600
`define EPC_ARR_LAST      16'hb7ff
`define EPC_CFG_ADDR      16'h103f
`define EPC_IDX_W         9
`define EPC_ROW_SHIFT     4
`define EPC_BIT_PGM       0
`define EPC_BIT_EEPROM_LATCH_BIT     1
`define EPC_BIT_ERASE     2
`define EPC_BIT_ROW       3
`define EPC_BIT_BYTE      4
`define EPC_BIT_RLAT      5
`define EPC_CTRL_RST      8'h00
`define EPC_ERASED        8'hff
`define EPC_CTRL_MASK     8'h3f
`endif

// ===== verilog/epc_pkg.sv
// types for the eeprom program/erase controller
package epc_pkg;
  typedef enum logic [1:0] {EPC_OP_PROG, EPC_OP_BYTE, EPC_OP_ROW, EPC_OP_BULK} epc_op_t;
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } epc_bus_t;
endpackage
